// ==== logic/external_bus_control.sv ====
// external memory bus control: register slave, pin ownership, wait states, write styles
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module external_bus_control #(
  parameter logic [20:0] ONCHIP_SIZE = ext_bus_pkg::ONCHIP_SIZE_DEF
) (
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  input  wire logic [31:0]             awaddr,
  input  wire logic                    awvalid,
  output      logic                    awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output      logic                    wready,
  output      logic [1:0]              bresp,
  output      logic                    bvalid,
  input  wire logic                    bready,
  input  wire logic [31:0]             araddr,
  input  wire logic                    arvalid,
  output      logic                    arready,
  output      logic [31:0]             rdata,
  output      logic [1:0]              rresp,
  output      logic                    rvalid,
  input  wire logic                    rready,
  input  wire ext_bus_pkg::static_cfg_t staticCfg,
  input  wire ext_bus_pkg::table_op_t  tableOp,
  input  wire logic [20:0]             fetchAddr,
  input  wire logic                    fetchExternal,
  output      logic                    cpuStall,
  output      ext_bus_pkg::bus_pins_t  busPins,
  output      logic                    portDOwnedByBus,
  output      logic                    portEOwnedByBus,
  output      logic                    portHOwnedByBus,
  output      logic                    portJOwnedByBus,
  output      logic [7:0]              portHIoMask,
  output      logic                    portDPullupEnable,
  output      logic                    portEPullupEnable,
  output      logic                    portJPullupEnable
);
  import ext_bus_pkg::*;

  logic [7:0]  externalBusControl;
  logic [2:0]  portGLatch;
  logic        wrAddrHeld;
  logic        wrDataHeld;
  logic [31:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic        regsEnabled;
  logic        busReleaseToPorts;
  logic [1:0]  waitField;
  logic [1:0]  writeStyle;
  logic [1:0]  waitCycles;
  logic [1:0]  waitLeft;
  logic [7:0]  tcyCount;
  logic        tcyTick;
  logic [7:0]  evenLatchedByte;
  logic        busActive;
  op_state_t   state;
  table_op_t   opHeld;
  logic [20:0] busAddr;
  logic [20:0] rawAddr;
  bus_pins_t   next_busPins;
  logic        next_portD;
  logic        next_portE;
  logic        next_port_h_pins;
  logic        busFirst;
  logic [20:0] shiftedFetch;

  if (TCY_CYCLES < 1 || TCY_CYCLES > 256) begin : g_tcy_check
    $error("instruction cycle must be 1 to 256 clocks");
  end

  assign regsEnabled       = (staticCfg.memoryModeAndAddressWidth != MODE_MCU);
  assign busReleaseToPorts = externalBusControl[RELEASE_BIT];
  assign waitField         = externalBusControl[WAIT_LSB +: 2];
  assign writeStyle        = externalBusControl[1:0];
  // 11 -> 0, 00 -> 3: the delay is the field inverted
  assign waitCycles        = staticCfg.waitEnable ? ~waitField : 2'h0;

  // write channel: address and data accepted in either order
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrAddrHeld <= 1'b0;
      wrDataHeld <= 1'b0;
      wrAddr     <= 32'h0000_0000;
      wrData     <= 32'h0000_0000;
      wrStrb     <= 4'h0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        wrAddrHeld <= 1'b1;
        wrAddr     <= awaddr;
      end
      if (wvalid && wready) begin
        wrDataHeld <= 1'b1;
        wrData     <= wdata;
        wrStrb     <= wstrb;
      end
      if (wrAddrHeld && wrDataHeld && !bvalid) begin
        wrAddrHeld <= 1'b0;
        wrDataHeld <= 1'b0;
        bvalid     <= 1'b1;
        if (wrAddr == ADDR_BUS_CONTROL || wrAddr == ADDR_PORT_G ||
            wrAddr == ADDR_STATUS) begin
          bresp <= RESP_OKAY;
        end else begin
          bresp <= RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  assign awready = !wrAddrHeld && !bvalid;
  assign wready  = !wrDataHeld && !bvalid;

  // control register; silently keeps its value in microcontroller mode
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      externalBusControl <= BUS_CONTROL_RST;
    end else if (wrAddrHeld && wrDataHeld && !bvalid && wrStrb[0] && regsEnabled &&
                 wrAddr == ADDR_BUS_CONTROL) begin
      externalBusControl <= wrData[7:0] & BUS_CONTROL_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      portGLatch <= PULLUP_RST;
    end else if (wrAddrHeld && wrDataHeld && !bvalid && wrStrb[0] &&
                 wrAddr == ADDR_PORT_G) begin
      portGLatch <= wrData[PULLUP_LSB +: 3];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      portDPullupEnable <= 1'b0;
      portEPullupEnable <= 1'b0;
      portJPullupEnable <= 1'b0;
    end else begin
      portDPullupEnable <= portGLatch[0];
      portEPullupEnable <= portGLatch[1];
      portJPullupEnable <= portGLatch[2];
    end
  end

  // read channel
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= RESP_OKAY;
      if (araddr == ADDR_BUS_CONTROL) begin
        rdata <= {24'h00_0000, externalBusControl};
      end else if (araddr == ADDR_PORT_G) begin
        rdata <= {24'h00_0000, portGLatch, 5'h00};
      end else if (araddr == ADDR_STATUS) begin
        rdata <= {24'h00_0000, staticCfg, busActive, state};
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  assign arready = !rvalid;

  // instruction-cycle enable from the system clock
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tcyCount <= 8'h00;
    end else if (tcyTick) begin
      tcyCount <= 8'h00;
    end else begin
      tcyCount <= tcyCount + 8'h01;
    end
  end

  assign tcyTick = (tcyCount == 8'(TCY_CYCLES - 1));

  // table operation: one bus cycle, then whole instruction cycles of wait
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state    <= ST_IDLE;
      opHeld   <= '0;
      waitLeft <= 2'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (tableOp.valid && tableOp.external && regsEnabled) begin
            opHeld <= tableOp;
            state  <= ST_BUS;
          end
        end
        ST_BUS: begin
          if (tcyTick && !busFirst) begin
            waitLeft <= waitCycles;
            state    <= (waitCycles == 2'h0) ? ST_IDLE : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (tcyTick) begin
            waitLeft <= waitLeft - 2'h1;
            if (waitLeft == 2'h1) begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cpuStall <= 1'b0;
    end else begin
      cpuStall <= (state == ST_WAIT && !(tcyTick && waitLeft == 2'h1)) ||
                  (state == ST_BUS && tcyTick && !busFirst && waitCycles != 2'h0);
    end
  end

  // first cycle of a table op carries the address, so a late request still latches it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busFirst <= 1'b0;
    end else begin
      busFirst <= (state == ST_IDLE) && tableOp.valid && tableOp.external && regsEnabled;
    end
  end

  // even byte held for word write pairs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      evenLatchedByte <= 8'h00;
    end else if (state == ST_IDLE && tableOp.valid && tableOp.external && tableOp.isWrite &&
                 !tableOp.tablePointer[0]) begin
      evenLatchedByte <= tableOp.tableDataLatch;
    end
  end

  // address shown on the bus
  assign rawAddr = (state == ST_IDLE) ? fetchAddr : opHeld.tablePointer;
  assign busAddr = staticCfg.addressOffsetEnable ? rawAddr - ONCHIP_SIZE : rawAddr;
  assign shiftedFetch = fetchAddr - ONCHIP_SIZE;

  assign busActive = (state != ST_IDLE) || fetchExternal;

  always_comb begin
    next_busPins = '0;
    next_busPins.chipEnable_n      = 1'b1;
    next_busPins.outputEnable_n    = 1'b1;
    next_busPins.lowWriteStrobe_n  = 1'b1;
    next_busPins.highWriteStrobe_n = 1'b1;
    next_busPins.lowerByteEnable_n = 1'b1;
    next_busPins.upperByteEnable_n = 1'b1;
    if (regsEnabled && busActive) begin
      next_busPins.chipEnable_n = 1'b0;
      next_busPins.adOut        = busAddr[16:1];
      next_busPins.adOe         = 16'hFFFF;
      next_busPins.upperAddr    = busAddr[20:17];
      next_busPins.upperAddrOe  = 4'hF;
      next_busPins.byteAddressLsb = busAddr[0];
      next_busPins.addressLatch = (state == ST_BUS) && busFirst;
      if (state == ST_BUS && opHeld.isWrite && !busFirst) begin
        if (!staticCfg.dataWidthSelect) begin
          // 8-bit data: style field has no say
          next_busPins.adOut[7:0]       = opHeld.tableDataLatch;
          next_busPins.lowWriteStrobe_n = 1'b0;
        end else if (writeStyle[1]) begin
          if (opHeld.tablePointer[0]) begin
            next_busPins.adOut = {opHeld.tableDataLatch, evenLatchedByte};
            next_busPins.highWriteStrobe_n = 1'b0;
            next_busPins.lowerByteEnable_n = 1'b0;
            next_busPins.upperByteEnable_n = 1'b0;
          end else begin
            next_busPins.adOe = 16'h0000;
          end
        end else if (writeStyle[0]) begin
          next_busPins.adOut = {2{opHeld.tableDataLatch}};
          next_busPins.highWriteStrobe_n = 1'b0;
          next_busPins.upperByteEnable_n = !opHeld.tablePointer[0];
          next_busPins.lowerByteEnable_n = opHeld.tablePointer[0];
        end else begin
          next_busPins.adOut = {2{opHeld.tableDataLatch}};
          next_busPins.highWriteStrobe_n = !opHeld.tablePointer[0];
          next_busPins.lowWriteStrobe_n  = opHeld.tablePointer[0];
        end
      end else if ((state == ST_BUS ? !busFirst : tcyCount != 8'h00) &&
                   !(state == ST_BUS && opHeld.isWrite)) begin
        next_busPins.adOe           = 16'h0000;
        next_busPins.outputEnable_n = 1'b0;
        next_busPins.lowerByteEnable_n = 1'b0;
        next_busPins.upperByteEnable_n = 1'b0;
      end
      if (staticCfg.memoryModeAndAddressWidth != MODE_ADDR20) begin
        next_busPins.upperAddrOe = 4'h0;
      end
      if (staticCfg.memoryModeAndAddressWidth == MODE_ADDR12) begin
        next_busPins.adOe[15:12] = 4'h0;
      end
    end
  end

  // ownership: bit clear keeps bus always, bit set only during external access
  always_comb begin
    next_portD = regsEnabled && (!busReleaseToPorts || busActive);
    next_portE = next_portD;
    next_port_h_pins = next_portD && (staticCfg.memoryModeAndAddressWidth == MODE_ADDR20);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busPins         <= '{chipEnable_n: 1'b1, outputEnable_n: 1'b1, lowWriteStrobe_n: 1'b1,
                           highWriteStrobe_n: 1'b1, lowerByteEnable_n: 1'b1,
                           upperByteEnable_n: 1'b1, default: '0};
      portDOwnedByBus <= 1'b0;
      portEOwnedByBus <= 1'b0;
      portHOwnedByBus <= 1'b0;
      portJOwnedByBus <= 1'b0;
      portHIoMask     <= 8'hFF;
    end else begin
      busPins         <= next_busPins;
      portDOwnedByBus <= next_portD;
      portEOwnedByBus <= next_portE;
      portHOwnedByBus <= next_port_h_pins;
      portJOwnedByBus <= next_portD;
      portHIoMask     <= next_port_h_pins ? 8'hF0 : 8'hFF;
    end
  end

  property p_mcu_no_write;
    @(posedge clk_sys) disable iff (!arst_n)
    (staticCfg.memoryModeAndAddressWidth == MODE_MCU) |=> $stable(externalBusControl);
  endproperty
  a_mcu_no_write: assert property (p_mcu_no_write)
    else $error("register changed in mcu mode");

  property p_own_clear;
    @(posedge clk_sys) disable iff (!arst_n)
    (regsEnabled && !busReleaseToPorts) |=> portDOwnedByBus;
  endproperty
  a_own_clear: assert property (p_own_clear)
    else $error("bus lost pins with release clear");

  property p_mcu_ports;
    @(posedge clk_sys) disable iff (!arst_n)
    !regsEnabled |=> !portDOwnedByBus && busPins.chipEnable_n;
  endproperty
  a_mcu_ports: assert property (p_mcu_ports)
    else $error("bus active in mcu mode");

  property p_wait_len;
    @(posedge clk_sys) disable iff (!arst_n)
    (state == ST_BUS && tcyTick && !busFirst && waitCycles == 2'h0) |=> state == ST_IDLE;
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("zero wait did not end op");

  property p_h_free;
    @(posedge clk_sys) disable iff (!arst_n)
    (staticCfg.memoryModeAndAddressWidth != MODE_ADDR20) |=> !portHOwnedByBus;
  endproperty
  a_h_free: assert property (p_h_free)
    else $error("port h taken in narrow width");

  property p_pullup;
    @(posedge clk_sys) disable iff (!arst_n)
    1'b1 |=> {portJPullupEnable, portEPullupEnable, portDPullupEnable} == $past(portGLatch);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up enable mismatch");

  property p_idle_pins;
    @(posedge clk_sys) disable iff (!arst_n)
    (!busActive) |=> busPins.chipEnable_n && !busPins.addressLatch && busPins.adOe == 16'h0000;
  endproperty
  a_idle_pins: assert property (p_idle_pins)
    else $error("idle bus pins wrong");

  property p_shift;
    @(posedge clk_sys) disable iff (!arst_n)
    (state == ST_IDLE && fetchExternal && regsEnabled && staticCfg.addressOffsetEnable)
    |=> {busPins.upperAddr, busPins.adOut, busPins.byteAddressLsb} == $past(shiftedFetch);
  endproperty
  a_shift: assert property (p_shift)
    else $error("shifted address wrong");
endmodule // external_bus_control

// ==== inc/ext_bus_pkg.sv ====
// constants and carriers for the external memory bus control block
// Contract
// - plain microcontroller mode disables the control register; writes ignored
// - release bit clear: bus owns pins permanently, port functions suppressed
// - release bit set: pins are ports, bus takes them during external access
// - release bit resets to zero, bus enabled by default
// - wait field 11/10/01/00 gives 0/1/2/3 instruction cycles of delay
// - wait field applies only when wait configuration bit is set
// - delay inserted right after the table operation's instruction cycle
// - write style 1x: word write, high strobe on odd byte, both bytes out
// - write style 01: byte select, latch on both bytes, high strobe plus byte enable
// - write style 00: byte write, latch on both bytes, high or low strobe
// - write style ignored in 8-bit data width
// - static data width bit: set selects 16 bits, clear selects 8 bits
// - static two-bit field picks memory mode and address width; 01 is 16-bit
// - unused high address lines become dedicated I/O regardless of release bit; only port H (A19:16) is freed, AD15:12 in 12-bit mode are just tri-stated
// - data always multiplexed onto low address lines
// - without offset, program counter driven unchanged as bus address
// - with offset enabled, on-chip memory size subtracted from bus address
// - 20-bit width drives byte address line as address lsb, byte enables select
// - pull-ups on all bus pins except top four; three port G bits enable D, E, J
// - every reset clears the three pull-up enable bits
// - microcontroller mode keeps bus inactive, pins are ports
// - idle bus: address/data tri-stated, strobes high, latch strobe and byte address low
package ext_bus_pkg;
  localparam logic [31:0] ADDR_BUS_CONTROL = 32'h0000_0000;
  localparam logic [31:0] ADDR_PORT_G      = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS      = 32'h0000_0008;
  localparam logic [7:0]  BUS_CONTROL_RST  = 8'h00;
  localparam logic [7:0]  BUS_CONTROL_MASK = 8'hB3;
  localparam logic [2:0]  PULLUP_RST       = 3'h0;
  localparam int          RELEASE_BIT      = 7;
  localparam int          WAIT_LSB         = 4;
  localparam int          PULLUP_LSB       = 5;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  localparam int          CLK_HZ           = 40_000_000;
  localparam int          TCY_NS           = 100;
  localparam int          TCY_CYCLES       = (TCY_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [20:0] ONCHIP_SIZE_DEF  = 21'h00_8000;

  typedef enum logic [1:0] {
    MODE_ADDR20 = 2'b00,
    MODE_ADDR16 = 2'b01,
    MODE_ADDR12 = 2'b10,
    MODE_MCU    = 2'b11
  } mem_mode_t;

  typedef struct packed {
    logic      addressOffsetEnable;
    logic      waitEnable;
    logic      dataWidthSelect;
    mem_mode_t memoryModeAndAddressWidth;
  } static_cfg_t;

  typedef struct packed {
    logic        valid;
    logic        isWrite;
    logic        external;
    logic [20:0] tablePointer;
    logic [7:0]  tableDataLatch;
  } table_op_t;

  typedef struct packed {
    logic [15:0] adOut;
    logic [15:0] adOe;
    logic [3:0]  upperAddr;
    logic [3:0]  upperAddrOe;
    logic        chipEnable_n;
    logic        outputEnable_n;
    logic        lowWriteStrobe_n;
    logic        highWriteStrobe_n;
    logic        addressLatch;
    logic        byteAddressLsb;
    logic        lowerByteEnable_n;
    logic        upperByteEnable_n;
  } bus_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUS  = 2'b01,
    ST_WAIT = 2'b10
  } op_state_t;
endpackage

// ==== dv/external_memory_model.sv ====
// behavioural external parallel memory watching the multiplexed bus
`timescale 1ns/100ps
module external_memory_model (
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire ext_bus_pkg::bus_pins_t busPins,
  output      logic [15:0]            memAddr,
  output      logic                   memLsb,
  output      logic [15:0]            memData,
  output      logic [7:0]             highWrites,
  output      logic [7:0]             lowWrites
);
  import ext_bus_pkg::*;
  logic prevHigh_n;
  logic prevLow_n;

  // glue latch: address captured while the latch strobe is high
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      memAddr <= 16'h0000;
      memLsb  <= 1'b0;
    end else if (busPins.addressLatch) begin
      memAddr <= busPins.adOut;
      memLsb  <= busPins.byteAddressLsb;
    end
  end

  // count strobe assertions, keep the data seen while a strobe is low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prevHigh_n <= 1'b1;
      prevLow_n  <= 1'b1;
      highWrites <= 8'h00;
      lowWrites  <= 8'h00;
      memData    <= 16'h0000;
    end else begin
      prevHigh_n <= busPins.highWriteStrobe_n;
      prevLow_n  <= busPins.lowWriteStrobe_n;
      if (!busPins.highWriteStrobe_n && prevHigh_n) highWrites <= highWrites + 8'h01;
      if (!busPins.lowWriteStrobe_n && prevLow_n) lowWrites <= lowWrites + 8'h01;
      if (!busPins.highWriteStrobe_n || !busPins.lowWriteStrobe_n) memData <= busPins.adOut;
    end
  end
endmodule // external_memory_model

// ==== dv/external_bus_control_tb.sv ====
// self-checking bench for the external memory bus control block
`timescale 1ns/100ps
`define CHECK_EQ(act, exp) begin totalChecks++; if ((act) !== (exp)) begin mismatches++; $display("MISMATCH t=%0t act=%h exp=%h", $time, (act), (exp)); end end
module external_bus_control_tb;
  import ext_bus_pkg::*;
  localparam logic [20:0] ONCHIP = 21'h00_8000;
  localparam logic [7:0]  STYLE_CTRL [3] = '{8'h32, 8'h31, 8'h30};
  localparam logic [20:0] STYLE_PTR [3]  = '{21'h01_0021, 21'h01_0021, 21'h01_0020};
  localparam logic [7:0]  STYLE_DATA [3] = '{8'hA5, 8'h3C, 8'hC3};
  localparam logic [31:0] STYLE_EXP [3]  = '{32'h0100_A55A, 32'h0100_3C3C, 32'h0001_C3C3};
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, cpuStall;
  logic [1:0]  bresp, rresp;
  static_cfg_t staticCfg = '0;
  table_op_t   tableOp = '0;
  logic [20:0] fetchAddr = 21'h01_0000;
  logic        fetchExternal = 1'b0;
  bus_pins_t   busPins;
  logic        portDOwnedByBus, portEOwnedByBus, portHOwnedByBus, portJOwnedByBus;
  logic [7:0]  portHIoMask, highWrites, lowWrites;
  logic        portDPullupEnable, portEPullupEnable, portJPullupEnable, memLsb;
  logic [15:0] memAddr, memData;
  int          mismatches = 0;
  int          totalChecks = 0;

  always #12.5 clk_sys = ~clk_sys;

  external_bus_control #(.ONCHIP_SIZE(ONCHIP)) external_bus_control_inst (
    .clk_sys, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .staticCfg, .tableOp, .fetchAddr, .fetchExternal, .cpuStall, .busPins,
    .portDOwnedByBus, .portEOwnedByBus, .portHOwnedByBus, .portJOwnedByBus, .portHIoMask,
    .portDPullupEnable, .portEPullupEnable, .portJPullupEnable
  );

  external_memory_model external_memory_model_inst (
    .clk_sys, .arst_n, .busPins, .memAddr, .memLsb, .memData, .highWrites, .lowWrites
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic axiWrite(input logic [31:0] a, input logic [7:0] v);
    int n;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= {24'h0, v};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 64) begin
      mismatches++;
      complete_run();
    end
    `CHECK_EQ(bresp, RESP_OKAY)
    bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 64) begin
      mismatches++;
      complete_run();
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // one-cycle table request, then count stall cycles over a window longer than 3 Tcy
  task automatic tableRun(input logic w, input logic [20:0] p, input logic [7:0] d,
                          output int stalls);
    @(posedge clk_sys);
    tableOp <= '{valid: 1'b1, isWrite: w, external: 1'b1, tablePointer: p, tableDataLatch: d};
    @(posedge clk_sys);
    tableOp.valid <= 1'b0;
    stalls = 0;
    repeat (40) begin
      @(posedge clk_sys);
      if (cpuStall === 1'b1) stalls++;
    end
  endtask

  // static configuration only changes while reset is held
  task automatic doReset(input static_cfg_t c);
    @(posedge clk_sys);
    arst_n    <= 1'b0;
    staticCfg <= c;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
  endtask

  initial begin
    logic [31:0] d32;
    logic [1:0]  r;
    logic [7:0]  h0;
    logic [7:0]  l0;
    int          s;
    // address width kept at or above data width
    doReset('{1'b0, 1'b1, 1'b1, MODE_ADDR20});
    axiRead(ADDR_BUS_CONTROL, d32, r);
    `CHECK_EQ(d32[7:0], BUS_CONTROL_RST)
    `CHECK_EQ({portDPullupEnable, portEPullupEnable, portJPullupEnable}, PULLUP_RST)
    `CHECK_EQ({portDOwnedByBus, portEOwnedByBus, portHOwnedByBus, portJOwnedByBus}, 4'hF)
    `CHECK_EQ({busPins.chipEnable_n, busPins.highWriteStrobe_n, busPins.addressLatch, busPins.byteAddressLsb}, 4'hC)
    `CHECK_EQ(busPins.adOe, 16'h0000)
    axiWrite(ADDR_BUS_CONTROL, 8'hFF);
    axiRead(ADDR_BUS_CONTROL, d32, r);
    `CHECK_EQ(d32, {24'h0, BUS_CONTROL_MASK})
    axiRead(32'h0000_0040, d32, r);
    `CHECK_EQ({r, d32}, {RESP_SLVERR, 32'h0})
    axiWrite(ADDR_BUS_CONTROL, 8'h80);
    repeat (2) @(posedge clk_sys);
    `CHECK_EQ(portDOwnedByBus, 1'b0)
    fetchExternal <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHECK_EQ(portDOwnedByBus, 1'b1)
    fetchExternal <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      axiWrite(ADDR_BUS_CONTROL, 8'(c << WAIT_LSB));
      tableRun(1'b0, 21'h01_0021, 8'h00, s);
      `CHECK_EQ(s, TCY_CYCLES * (3 - c))
    end
    `CHECK_EQ({memLsb, memAddr}, 17'h1_8010)
    // even half of a word write is held, nothing strobed
    axiWrite(ADDR_BUS_CONTROL, 8'h32);
    h0 = highWrites;
    l0 = lowWrites;
    tableRun(1'b1, 21'h01_0020, 8'h5A, s);
    `CHECK_EQ({highWrites - h0, lowWrites - l0}, 16'h0000)
    for (int i = 0; i < 3; i++) begin
      axiWrite(ADDR_BUS_CONTROL, STYLE_CTRL[i]);
      h0 = highWrites;
      l0 = lowWrites;
      tableRun(1'b1, STYLE_PTR[i], STYLE_DATA[i], s);
      `CHECK_EQ({highWrites - h0, lowWrites - l0, memData}, STYLE_EXP[i])
    end
    axiWrite(ADDR_PORT_G, 8'hE0);
    repeat (2) @(posedge clk_sys);
    `CHECK_EQ({portDPullupEnable, portEPullupEnable, portJPullupEnable}, 3'h7)
    axiWrite(ADDR_PORT_G, 8'h40);
    repeat (2) @(posedge clk_sys);
    `CHECK_EQ({portDPullupEnable, portEPullupEnable, portJPullupEnable}, 3'h2)
    doReset('{1'b1, 1'b0, 1'b1, MODE_ADDR16});
    `CHECK_EQ({portDPullupEnable, portEPullupEnable, portJPullupEnable}, PULLUP_RST)
    `CHECK_EQ({portHOwnedByBus, portHIoMask}, 9'h0FF)
    tableRun(1'b0, ONCHIP + 21'h00_0021, 8'h00, s);
    `CHECK_EQ(s, 0)
    `CHECK_EQ({memLsb, memAddr}, 17'h1_0010)
    fetchExternal <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHECK_EQ({busPins.adOut, busPins.byteAddressLsb}, 17'h0_8000)
    fetchExternal <= 1'b0;
    doReset('{1'b0, 1'b1, 1'b1, MODE_MCU});
    axiWrite(ADDR_BUS_CONTROL, 8'h35);
    axiRead(ADDR_BUS_CONTROL, d32, r);
    `CHECK_EQ(d32[7:0], BUS_CONTROL_RST)
    `CHECK_EQ({portDOwnedByBus, portEOwnedByBus, portHOwnedByBus, portJOwnedByBus}, 4'h0)
    complete_run();
  end
endmodule // external_bus_control_tb
